// File: wsl_wiper_serial_load.sv
// serial receiver and wiper setting register with tap decode
// Function
// - eight-bit word, msb first; first received bit lands at the top bit.
// - while select is high, shift data in on each rising serial clock edge.
// - on select falling, copy the shift register into the wiper setting.
// - more than eight bits: earliest ones drop out, the final eight kept.
// - decode the code into exactly one of 256 taps; code 0 is low end.
// - each code step moves one tap up; code 255 is the last tap.
// - at power-up the wiper setting holds midscale code 128.
// - three inputs only: data, select, serial clock; no readback path.
// - select is active high; its falling edge commits the received word.
`timescale 1ns/10ps
module wsl_wiper_serial_load #(
  parameter int SYNC_STAGES = wsl_pkg::SYNC_STAGES
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         serial_in_line,
  input  wire logic         select_line,
  input  wire logic         serial_clock,
  output logic [7:0]        wiper_setting,
  output logic [255:0]      tap_select
);
  // synchroniser depth limits: two flops at least, no deeper than the checks expect
  localparam int           MIN_SYNC  = 2;
  localparam int           MAX_SYNC  = 8;
  // pin edge to edge seen, and pin edge to register updated, in clk cycles
  localparam int           EDGE_LAT  = SYNC_STAGES;
  localparam int           LOAD_LAT  = SYNC_STAGES + 1;
  localparam logic [255:0] TAP_RESET = 256'h1 << wsl_pkg::WIPER_RESET;

  // a shallower chain lets metastable pin samples reach the edge detectors
  if (SYNC_STAGES < MIN_SYNC || SYNC_STAGES > MAX_SYNC) begin : bad_sync_depth_g
    $error("synchroniser depth out of range");
  end
  // the port widths are fixed; the package must agree with them
  if (wsl_pkg::WORD_BITS != $bits(wiper_setting) || wsl_pkg::TAP_COUNT != $bits(tap_select)) begin : bad_word_size_g
    $error("word width or tap count disagrees with the ports");
  end

  logic [SYNC_STAGES-1:0] din_sync_reg;
  logic [SYNC_STAGES-1:0] sel_sync_reg;
  logic [SYNC_STAGES-1:0] sck_sync_reg;
  logic       sel_prev_reg;
  logic       sck_prev_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] wiper_setting_reg;
  logic [7:0] wiper_setting_next;
  logic [255:0] tap_reg;
  logic [255:0] tap_next;

  wire din_s    = din_sync_reg[SYNC_STAGES-1];
  wire sel_s    = sel_sync_reg[SYNC_STAGES-1];
  wire sck_s    = sck_sync_reg[SYNC_STAGES-1];
  wire sck_rise = sck_s & ~sck_prev_reg;
  wire sel_fall = ~sel_s & sel_prev_reg;
  wire do_shift = sel_s & sck_rise;

  // one-hot tap decode
  function automatic logic [255:0] wsl_decode(input logic [7:0] code);
    logic [255:0] v;
    v = '0;
    v[code] = 1'b1;
    return v;
  endfunction : wsl_decode

  // newest bit enters at bit 0 so the earliest bit ends at the top
  assign shift_next = do_shift ? {shift_reg[6:0], din_s} : shift_reg;
  assign wiper_setting_next = sel_fall ? shift_reg : wiper_setting_reg;
  assign tap_next = wsl_decode(wiper_setting_next);

  // each pin passes the whole chain before any logic reads it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din_sync_reg <= '0;
    end else begin
      din_sync_reg <= {din_sync_reg[SYNC_STAGES-2:0], serial_in_line};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_sync_reg <= '0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[SYNC_STAGES-2:0], select_line};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_sync_reg <= '0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[SYNC_STAGES-2:0], serial_clock};
    end
  end

  // edge history resets to the idle-low pin level so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_prev_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_s;
      sck_prev_reg <= sck_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg <= wsl_pkg::CODE_ZERO;
    end else begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wiper_setting_reg <= wsl_pkg::WIPER_RESET;
      tap_reg           <= TAP_RESET;
    end else begin
      wiper_setting_reg <= wiper_setting_next;
      tap_reg           <= tap_next;
    end
  end

  assign wiper_setting = wiper_setting_reg;
  assign tap_select    = tap_reg;

  sequence sel_falls_s;
    sel_prev_reg && !sel_s;
  endsequence

  sequence sck_rises_s;
    sck_s && !sck_prev_reg;
  endsequence

  sequence framed_rise_s;
    sel_s && sck_s && !sck_prev_reg;
  endsequence

  sequence load_word_s;
    wiper_setting_reg == $past(shift_reg);
  endsequence

  commit_word_a: assert property (@(posedge clk) disable iff (rst)
    sel_falls_s |=> load_word_s)
    else $error("wiper setting not loaded on select fall");

  hold_setting_a: assert property (@(posedge clk) disable iff (rst)
    !sel_fall |=> $stable(wiper_setting_reg))
    else $error("wiper setting changed without select fall");

  shift_in_a: assert property (@(posedge clk) disable iff (rst)
    framed_rise_s |=> shift_reg[0] == $past(din_s))
    else $error("data bit not shifted in");

  msb_first_a: assert property (@(posedge clk) disable iff (rst)
    framed_rise_s |=> shift_reg[7:1] == $past(shift_reg[6:0]))
    else $error("shift direction wrong");

  no_shift_a: assert property (@(posedge clk) disable iff (rst)
    !do_shift |=> $stable(shift_reg))
    else $error("shift register moved without a framed edge");

  onehot_tap_a: assert property (@(posedge clk) disable iff (rst)
    $onehot(tap_reg))
    else $error("tap select not one-hot");

  tap_match_a: assert property (@(posedge clk) disable iff (rst)
    tap_reg[wiper_setting_reg])
    else $error("tap does not match setting code");

  reset_mid_a: assert property (@(posedge clk)
    $fell(rst) |-> wiper_setting_reg == wsl_pkg::WIPER_RESET)
    else $error("setting not midscale after reset");

  // pin-level checks: serial clock rises and select edges reach the logic after exactly EDGE_LAT cycles, framed data bits after LOAD_LAT
  sck_seen_a: assert property (@(posedge clk) disable iff (rst)
    $rose(serial_clock) |-> ##EDGE_LAT sck_rises_s)
    else $error("serial clock edge not seen in time");

  sel_seen_a: assert property (@(posedge clk) disable iff (rst)
    $rose(select_line) |-> ##EDGE_LAT (sel_s && !sel_prev_reg))
    else $error("select rise not seen in time");

  commit_delay_a: assert property (@(posedge clk) disable iff (rst)
    $fell(select_line) |-> ##EDGE_LAT sel_falls_s ##1 load_word_s)
    else $error("word not committed after select fall");

  data_sample_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(serial_clock) && select_line) |-> ##LOAD_LAT shift_reg[0] == $past(serial_in_line, LOAD_LAT))
    else $error("data pin not sampled at the framed edge");

  unframed_ignored_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(serial_clock) && !select_line) |-> ##LOAD_LAT $stable(shift_reg))
    else $error("unframed clock edge shifted data");

  tap_low_end_a: assert property (@(posedge clk) disable iff (rst)
    wiper_setting_reg == wsl_pkg::CODE_ZERO |-> tap_reg[0])
    else $error("code zero not at the low end");

  tap_high_end_a: assert property (@(posedge clk) disable iff (rst)
    wiper_setting_reg == wsl_pkg::CODE_FULL |-> tap_reg[255])
    else $error("full code not at the last tap");

  tap_step_a: assert property (@(posedge clk) disable iff (rst)
    ($past(wiper_setting_reg) != wsl_pkg::CODE_FULL && wiper_setting_reg == $past(wiper_setting_reg) + 8'h01)
      |-> tap_reg == ($past(tap_reg) << 1))
    else $error("one code step did not move one tap");

  commit_tap_a: assert property (@(posedge clk) disable iff (rst)
    sel_falls_s |=> tap_reg == (256'h1 << $past(shift_reg)))
    else $error("tap not updated with committed word");

  reset_tap_a: assert property (@(posedge clk)
    $fell(rst) |-> tap_reg == TAP_RESET)
    else $error("tap not midscale after reset");

  wiper_unframed_a: assert property (@(posedge clk) disable iff (rst)
    (!sel_s && !sel_prev_reg) |=> $stable(wiper_setting_reg))
    else $error("wiper setting moved outside a frame");

  tap_hold_a: assert property (@(posedge clk) disable iff (rst)
    !sel_fall |=> $stable(tap_reg))
    else $error("tap changed without select fall");
endmodule : wsl_wiper_serial_load

// File: wsl_pkg.sv
// package of constants for the wiper serial load block
package wsl_pkg;
  localparam int            WORD_BITS  = 8;
  localparam int            TAP_COUNT  = 256;
  localparam logic [7:0]    WIPER_RESET = 8'h80;
  localparam logic [7:0]    CODE_ZERO   = 8'h00;
  localparam logic [7:0]    CODE_FULL   = 8'hff;
  localparam int            SYNC_STAGES = 2;
endpackage : wsl_pkg

// File: wsl_host.sv
// host model driving the three-wire wiper load interface
`timescale 1ns/10ps
module wsl_host (
  input  wire logic clk,
  output logic      serial_in_line,
  output logic      select_line,
  output logic      serial_clock
);
  initial {serial_in_line, select_line, serial_clock} = 3'b000;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // n bits msb first; sel low sends clocks outside a frame
  task automatic xfer(input logic [15:0] w, input int n, input logic sel);
    select_line = sel;
    step(4);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line = w[i];
      step(4);
      serial_clock = 1'b1;
      step(4);
      serial_clock = 1'b0;
    end
    step(4);
    select_line = 1'b0;
    serial_in_line = ~serial_in_line;
    step(8);
  endtask : xfer
endmodule : wsl_host

// File: wiper_serial_load_tb_top.sv
// self-checking bench for the wiper serial load block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t bad %h", $time, a); end end
module wiper_serial_load_tb_top;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         serial_in_line, sel, sck;
  logic [7:0]   wiper_setting;
  logic [255:0] tap_select;
  logic [15:0]  w;
  int           mismatches = 0;
  int           comparisons = 0;
  int           seed = 32'h67bf2393;
  initial forever #50 clk = ~clk;
  wsl_host host (.clk(clk), .serial_in_line(serial_in_line), .select_line(sel), .serial_clock(sck));
  wsl_wiper_serial_load dut (.clk(clk), .rst(rst), .serial_in_line(serial_in_line), .select_line(sel),
    .serial_clock(sck), .wiper_setting(wiper_setting), .tap_select(tap_select));
  function automatic logic [255:0] onehot(input logic [7:0] c);
    return 256'h1 << c;
  endfunction : onehot
  task automatic check(input logic [7:0] c);
    `CHK(wiper_setting, c)
    `CHK(tap_select, onehot(c))
  endtask : check
  task automatic final_report;
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    #300000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    check(wsl_pkg::WIPER_RESET);
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0001 : (i == 2) ? 16'hffff : 16'($random(seed));
      host.xfer(w, (i > 9) ? 10 : 8, 1'b1);
      check(w[7:0]);
    end
    host.xfer(~w, 8, 1'b0);
    check(w[7:0]);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check(wsl_pkg::WIPER_RESET);
    w = 16'($random(seed));
    host.xfer(w, 9, 1'b1);
    check(w[7:0]);
    final_report();
  end
endmodule : wiper_serial_load_tb_top
